/* verilog/acotc_pkg.sv */
// Constants for the converter's global configuration and test-pattern block.
// Assumes a framed serial port delivers whole register reads and writes.
package acotc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_SERIAL_SETUP = 8'h00;
   localparam logic [7:0] ADDR_BURST_LAST = 8'h02;
   localparam logic [7:0] ADDR_DIVIDER = 8'h72;
   localparam logic [7:0] ADDR_OUT_FORMAT = 8'h73;
   localparam logic [7:0] ADDR_SECOND_OUT = 8'h74;
   localparam logic [7:0] ADDR_SPEED_STATUS = 8'h75;
   localparam logic [7:0] ADDR_PATTERN = 8'hC0;
   localparam logic [7:0] ADDR_W1_LOW = 8'hC2;
   localparam logic [7:0] ADDR_W1_HIGH = 8'hC3;
   localparam logic [7:0] ADDR_W2_LOW = 8'hC4;
   localparam logic [7:0] ADDR_W2_HIGH = 8'hC5;
   // Field positions
   localparam int SOFT_RESET_BIT = 5;
   localparam int DLL_RANGE_BIT = 6;
   localparam int DRIVE_MSB = 7;
   localparam int DRIVE_LSB = 5;
   localparam int TEST_MODE_MSB = 7;
   localparam int TEST_MODE_LSB = 6;
   localparam logic [7:0] OUT_FORMAT_MASK = 8'hE7;
   localparam logic [7:0] SPEED_STATUS_MASK = 8'h40;
   localparam logic [7:0] SETUP_KEEP_MASK = 8'hDF;
   // Values after reset
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_SETTING = 2'h0;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // One-hot field encodings
   localparam logic [2:0] SEL_PIN = 3'h0;
   localparam logic [2:0] SEL_FIRST = 3'h1;
   localparam logic [2:0] SEL_SECOND = 3'h2;
   localparam logic [2:0] SEL_THIRD = 3'h4;
   // Test-pattern sequencing
   localparam logic [1:0] TEST_STATIC = 2'h0;
   localparam logic [1:0] TEST_ALTERNATE = 2'h1;
   localparam logic [3:0] PAT_OFF = 4'h0;
   localparam logic [3:0] PAT_MID = 4'h1;
   localparam logic [3:0] PAT_ONES = 4'h2;
   localparam logic [3:0] PAT_ZEROS = 4'h3;
   localparam logic [3:0] PAT_CHECKER = 4'h4;
   localparam logic [3:0] PAT_ONE_ZERO = 4'h7;
   localparam logic [3:0] PAT_USER = 4'h8;
   localparam logic [15:0] WORD_MID = 16'h8000;
   localparam logic [15:0] WORD_ONES = 16'hFFFF;
   localparam logic [15:0] WORD_ZEROS = 16'h0000;
   localparam logic [15:0] WORD_CHECK_A = 16'hAAAA;
   localparam logic [15:0] WORD_CHECK_B = 16'h5555;
   localparam int TEST_SYNC_STAGES = 3;
   localparam int PIN_SYNC_STAGES = 2;
endpackage

/* verilog/acotc_top.sv */
// Global configuration registers, output overrides and test-pattern source.
// Assumes serial framing outside; one register access per strobe on clk_sys.
// Notes on behaviour
// - Divider field 000 follows the pin, 001 is /1, 010 is /2, 100 is /4.
// - Soft reset leaves the divider and output-format registers untouched.
// - Format bits 7:5: 000 pin, 001 low-swing 2mA, 010 3mA, 100 CMOS.
// - Format bits 2:0: 000 pin, 001 two's complement, 010 Gray, 100 binary.
// - Speed-status bit 6 picks the loop range, fast when clear by default.
// - Test words are held static or alternated on successive clock phases.
// - Pattern enable reaches the bus only after several clock cycles.
// - Test mode bits 7:6 are 00 static, 01 alternate, others reserved.
// - Low nibble picks off, midscale, ones, zeros, checkerboard, one/zero.
// - Code 1000 sends the first user word built from its two bytes.
// - The second user word, from its two bytes, is the alternate word.
// - An 8-bit register at 02 holds the burst's last address.
// - Writing the soft-reset bit returns all registers but the divider and output format to defaults.
module acotc_top
   import acotc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] divider_pin,
   input wire logic [1:0] drive_select_pin,
   input wire logic [1:0] coding_select_pin,
   input wire logic [15:0] sample_data,
   output logic [1:0] divider_ratio,
   output logic [1:0] drive_mode,
   output logic [1:0] coding_mode,
   output logic dll_slow,
   output logic test_active,
   output logic [15:0] out_bus
);
   logic [7:0] setup_reg;
   logic [7:0] burst_last_reg;
   logic [7:0] divider_reg;
   logic [7:0] out_format_reg;
   logic [7:0] second_out_reg;
   logic [7:0] speed_status_reg;
   logic [7:0] pattern_reg;
   logic [7:0] w1_low_reg;
   logic [7:0] w1_high_reg;
   logic [7:0] w2_low_reg;
   logic [7:0] w2_high_reg;
   logic [5:0] pin_sync1_reg;
   logic [5:0] pin_sync2_reg;
   logic [TEST_SYNC_STAGES-1:0] test_sync_reg;
   logic phase_reg;
   logic soft_reset;
   logic [15:0] word1;
   logic [15:0] word2;
   logic has_word2;
   logic pattern_on;

   // Pin codes: 0, 1, 2 are the three tri-level states; 3 is ignored
   function automatic logic [1:0] pick_setting(input logic [2:0] field,
         input logic [1:0] pin, input logic [1:0] prev);
      logic [1:0] result;
      result = prev;
      case (field)
         SEL_PIN: if (pin != 2'h3) result = pin;
         SEL_FIRST: result = 2'h0;
         SEL_SECOND: result = 2'h1;
         SEL_THIRD: result = 2'h2;
         default: result = prev;
      endcase
      return result;
   endfunction

   assign soft_reset = reg_wr && reg_addr == ADDR_SERIAL_SETUP
         && reg_wdata[SOFT_RESET_BIT];

   // Registers exempt from soft reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         divider_reg <= RESET_BYTE;
         out_format_reg <= RESET_BYTE;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_DIVIDER) begin
            divider_reg <= reg_wdata;
         end
         if (reg_addr == ADDR_OUT_FORMAT) begin
            out_format_reg <= reg_wdata & OUT_FORMAT_MASK;
         end
      end
   end

   // Registers that soft reset returns to defaults
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         setup_reg <= RESET_BYTE;
         burst_last_reg <= RESET_BYTE;
         second_out_reg <= RESET_BYTE;
         speed_status_reg <= RESET_BYTE;
         pattern_reg <= RESET_BYTE;
         w1_low_reg <= RESET_BYTE;
         w1_high_reg <= RESET_BYTE;
         w2_low_reg <= RESET_BYTE;
         w2_high_reg <= RESET_BYTE;
      end else if (soft_reset) begin
         setup_reg <= RESET_BYTE;
         burst_last_reg <= RESET_BYTE;
         second_out_reg <= RESET_BYTE;
         speed_status_reg <= RESET_BYTE;
         pattern_reg <= RESET_BYTE;
         w1_low_reg <= RESET_BYTE;
         w1_high_reg <= RESET_BYTE;
         w2_low_reg <= RESET_BYTE;
         w2_high_reg <= RESET_BYTE;
      end else if (reg_wr) begin
         case (reg_addr)
            // Soft-reset bit is self-clearing, so it never reads back high
            ADDR_SERIAL_SETUP: setup_reg <= reg_wdata & SETUP_KEEP_MASK;
            ADDR_BURST_LAST: burst_last_reg <= reg_wdata;
            // Host pre-mixes status in; undo it to recover its wanted value
            ADDR_SECOND_OUT: second_out_reg <= reg_wdata
                  ^ speed_status_reg ^ second_out_reg;
            ADDR_SPEED_STATUS:
               speed_status_reg <= reg_wdata & SPEED_STATUS_MASK;
            ADDR_PATTERN: pattern_reg <= reg_wdata;
            ADDR_W1_LOW: w1_low_reg <= reg_wdata;
            ADDR_W1_HIGH: w1_high_reg <= reg_wdata;
            ADDR_W2_LOW: w2_low_reg <= reg_wdata;
            ADDR_W2_HIGH: w2_high_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read answer; unmapped addresses read zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_SERIAL_SETUP: reg_rdata <= setup_reg;
            ADDR_BURST_LAST: reg_rdata <= burst_last_reg;
            ADDR_DIVIDER: reg_rdata <= divider_reg;
            ADDR_OUT_FORMAT: reg_rdata <= out_format_reg;
            ADDR_SECOND_OUT: reg_rdata <= second_out_reg;
            ADDR_SPEED_STATUS: reg_rdata <= speed_status_reg;
            ADDR_PATTERN: reg_rdata <= pattern_reg;
            ADDR_W1_LOW: reg_rdata <= w1_low_reg;
            ADDR_W1_HIGH: reg_rdata <= w1_high_reg;
            ADDR_W2_LOW: reg_rdata <= w2_low_reg;
            ADDR_W2_HIGH: reg_rdata <= w2_high_reg;
            default: reg_rdata <= RESET_BYTE;
         endcase
      end
   end

   // Strap pins are asynchronous to clk_sys
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_sync1_reg <= 6'h00;
         pin_sync2_reg <= 6'h00;
      end else begin
         pin_sync1_reg <= {coding_select_pin, drive_select_pin, divider_pin};
         pin_sync2_reg <= pin_sync1_reg;
      end
   end

   // Effective overrides
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         divider_ratio <= RESET_SETTING;
         drive_mode <= RESET_SETTING;
         coding_mode <= RESET_SETTING;
         dll_slow <= 1'b0;
      end else begin
         divider_ratio <= pick_setting(divider_reg[2:0],
               pin_sync2_reg[1:0], divider_ratio);
         drive_mode <= pick_setting(out_format_reg[DRIVE_MSB:DRIVE_LSB],
               pin_sync2_reg[3:2], drive_mode);
         coding_mode <= pick_setting(out_format_reg[2:0],
               pin_sync2_reg[5:4], coding_mode);
         dll_slow <= speed_status_reg[DLL_RANGE_BIT];
      end
   end

   // Pattern words per code; reserved codes act as off
   always_comb begin
      word1 = WORD_ZEROS;
      word2 = WORD_ZEROS;
      has_word2 = 1'b0;
      pattern_on = 1'b1;
      case (pattern_reg[3:0])
         PAT_MID: word1 = WORD_MID;
         PAT_ONES: word1 = WORD_ONES;
         PAT_ZEROS: word1 = WORD_ZEROS;
         PAT_CHECKER: begin
            word1 = WORD_CHECK_A;
            word2 = WORD_CHECK_B;
            has_word2 = 1'b1;
         end
         PAT_ONE_ZERO: begin
            word1 = WORD_ONES;
            word2 = WORD_ZEROS;
            has_word2 = 1'b1;
         end
         PAT_USER: begin
            word1 = {w1_high_reg, w1_low_reg};
            word2 = {w2_high_reg, w2_low_reg};
            has_word2 = 1'b1;
         end
         default: pattern_on = 1'b0;
      endcase
   end

   // Enable is treated as foreign to the sample clock, so it is delayed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         test_sync_reg <= '0;
      end else begin
         test_sync_reg <= {test_sync_reg[TEST_SYNC_STAGES-2:0],
               pattern_on};
      end
   end

   // Bus drive; reserved mode bits fall back to static
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_reg <= 1'b0;
         test_active <= 1'b0;
         out_bus <= RESET_WORD;
      end else begin
         test_active <= test_sync_reg[TEST_SYNC_STAGES-1];
         if (!test_sync_reg[TEST_SYNC_STAGES-1]) begin
            phase_reg <= 1'b0;
            out_bus <= sample_data;
         end else if (pattern_reg[TEST_MODE_MSB:TEST_MODE_LSB]
               == TEST_ALTERNATE && has_word2) begin
            phase_reg <= ~phase_reg;
            out_bus <= phase_reg ? word2 : word1;
         end else begin
            phase_reg <= 1'b0;
            out_bus <= word1;
         end
      end
   end
endmodule

/* bench/acotc_props.sv */
// Checker for register decode and pattern timing at the top ports.
// Bound onto every instance of the top module.
module acotc_props
   import acotc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] divider_ratio,
   input wire logic [1:0] drive_mode,
   input wire logic [1:0] coding_mode,
   input wire logic test_active,
   input wire logic [15:0] out_bus
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire w73 = reg_wr && reg_addr == ADDR_OUT_FORMAT;
   wire wb = reg_wr && reg_addr == ADDR_BURST_LAST;
   AST_DIV_ONE: assert property (reg_wr && reg_addr == ADDR_DIVIDER
      && reg_wdata == 8'h01 |-> ##2 divider_ratio == 2'h0)
      else $error("Divider one not applied");
   AST_DRIVE: assert property (w73 && reg_wdata[7:5] == 3'h2
      |-> ##2 drive_mode == 2'h1) else $error("Drive 3mA not applied");
   AST_CODING: assert property (w73 && reg_wdata[2:0] == 3'h4
      |-> ##2 coding_mode == 2'h2) else $error("Binary coding not applied");
   AST_FMT_RSVD: assert property (reg_rd && reg_addr == 8'h73
      |=> reg_rdata[4:3] == 2'h0) else $error("Format bits 4:3 not zero");
   AST_STATUS: assert property (reg_rd && reg_addr == 8'h75
      |=> (reg_rdata & 8'hBF) == 8'h00) else $error("Status extra bits");
   AST_BURST: assert property (wb ##2 reg_rd && reg_addr == 8'h02
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("Burst readback");
   AST_ONES: assert property (reg_wr && reg_addr == 8'hC0
      && reg_wdata[3:0] == 4'h2 |-> ##[3:6] test_active
      && out_bus == 16'hFFFF) else $error("Ones pattern late");
   AST_ALT: assert property (out_bus == 16'hFFFF ##1 out_bus == 0
      && test_active |=> !test_active || out_bus == 16'hFFFF)
      else $error("Alternation broken");
endmodule
bind acotc_top acotc_props u_acotc_props (.clk_sys, .rst, .reg_wr,
   .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .divider_ratio,
   .drive_mode, .coding_mode, .test_active, .out_bus);

/* bench/acotc_host.sv */
// Host model issuing single register accesses on the strobe bus.
// Assumes one clock; signals change 1 ns after the rising edge.
module acotc_host
   import acotc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr = 0,
   output logic reg_rd = 0,
   output logic [7:0] reg_addr = 8'hFF,
   output logic [7:0] reg_wdata = 8'h00
);
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [7:0] wd, output logic [7:0] q);
      @(posedge clk_sys);
      #1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = wd;
      @(posedge clk_sys);
      #1;
      reg_wr = 0;
      reg_rd = 0;
      // Released lines flip so stale values never look valid
      reg_addr = ~a;
      reg_wdata = ~wd;
      q = reg_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      logic [7:0] q;
      xfer(1'b1, a, wd, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic set_b(input logic [7:0] want);
      logic [7:0] b;
      logic [7:0] s;
      rd(ADDR_SECOND_OUT, b);
      rd(ADDR_SPEED_STATUS, s);
      wr(ADDR_SECOND_OUT, b ^ s ^ want);
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the configuration and pattern block.
// Host model drives the register strobes; bench drives pins and data.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import acotc_pkg::*;
   logic clk_sys = 0;
   logic rst = 1;
   logic reg_wr, reg_rd, dll_slow, test_active;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [1:0] divider_pin = 1, drive_select_pin = 1, coding_select_pin = 2;
   logic [1:0] divider_ratio, drive_mode, coding_mode;
   logic [15:0] sample_data = 0, out_bus, a, b, d = 0;
   logic [31:0] u, e;
   logic [7:0] dv [3] = '{8'h01, 8'h02, 8'h04};
   logic [3:0] pc [7] = '{1, 2, 3, 4, 7, 8, 5};
   logic [15:0] t1 [9] = '{0, 16'h8000, 16'hFFFF, 0, 16'hAAAA, 0, 0, 16'hFFFF, 0};
   logic [15:0] t2 [9] = '{0, 0, 0, 0, 16'h5555, 0, 0, 16'h0000, 0};
   int errors = 0, compares = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   acotc_top u_acotc_top (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .divider_pin, .drive_select_pin,
      .coding_select_pin, .sample_data, .divider_ratio, .drive_mode,
      .coding_mode, .dll_slow, .test_active, .out_bus);
   acotc_host u_acotc_host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic close_out;
      $display("Compares %0d, errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Second word falls back to the first in static mode or single words
   function automatic logic [31:0] pat(input logic [3:0] c, input int m);
      logic [15:0] x;
      logic [15:0] y;
      x = (c == 8) ? u[31:16] : t1[c];
      y = (c == 8) ? u[15:0] : t2[c];
      if (m == 0 || c < 4) y = x;
      return {x, y};
   endfunction
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      void'($urandom(93778));
      sample_data = 16'($urandom);
      u = $urandom;
      repeat (20) @(posedge clk_sys);
      #1;
      rst = 0;
      foreach (dv[i]) begin
         u_acotc_host.wr(ADDR_DIVIDER, dv[i]);
         settle(3);
         chk(divider_ratio, 16'(i));
      end
      u_acotc_host.wr(ADDR_DIVIDER, 8'h03);
      settle(3);
      chk(divider_ratio, 16'h2);
      u_acotc_host.wr(ADDR_DIVIDER, 8'h00);
      settle(6);
      chk(divider_ratio, 16'h1);
      u_acotc_host.wr(ADDR_BURST_LAST, u[7:0]);
      u_acotc_host.rd(ADDR_BURST_LAST, d[7:0]);
      chk(d, {8'h00, u[7:0]});
      // Slow range chosen as if sampling at 40 to 100 MSPS
      u_acotc_host.wr(ADDR_SPEED_STATUS, 8'hFF);
      // Range flag is registered one edge after the status register
      settle(1);
      chk(dll_slow, 16'h1);
      u_acotc_host.set_b(u[15:8]);
      u_acotc_host.rd(ADDR_SECOND_OUT, d[7:0]);
      chk(d, {8'h00, u[15:8]});
      $display("Divider, burst and status tests done");
      for (int k = 0; k < 3; k++) begin
         v = {3'h1 << k, 2'h3, 3'h4 >> k};
         u_acotc_host.wr(ADDR_OUT_FORMAT, v);
         settle(3);
         chk({drive_mode, coding_mode}, 16'(k * 4 + 2 - k));
         u_acotc_host.rd(ADDR_OUT_FORMAT, d[7:0]);
         chk(d, {8'h00, v & 8'hE7});
      end
      u_acotc_host.wr(ADDR_DIVIDER, 8'h04);
      u_acotc_host.wr(ADDR_SERIAL_SETUP, 8'h20);
      u_acotc_host.rd(ADDR_OUT_FORMAT, d[7:0]);
      chk(d, 16'h0081);
      u_acotc_host.rd(ADDR_DIVIDER, d[7:0]);
      chk(d, 16'h0004);
      u_acotc_host.rd(ADDR_BURST_LAST, d[7:0]);
      chk(d, 16'h0000);
      chk(dll_slow, 16'h0);
      $display("Format and soft reset tests done");
      u_acotc_host.wr(ADDR_W1_LOW, u[23:16]);
      u_acotc_host.wr(ADDR_W1_HIGH, u[31:24]);
      u_acotc_host.wr(ADDR_W2_LOW, u[7:0]);
      u_acotc_host.wr(ADDR_W2_HIGH, u[15:8]);
      foreach (pc[i]) for (int m = 0; m < 2; m++) begin
         u_acotc_host.wr(ADDR_PATTERN, {m[1:0], 2'h0, pc[i]});
         chk(test_active, 16'h0);
         settle(7);
         a = out_bus;
         settle(1);
         b = out_bus;
         e = (pc[i] == 5) ? {sample_data, sample_data} : pat(pc[i], m);
         chk(test_active, 16'(pc[i] != 5));
         chk(16'({a, b} == e || {b, a} == e), 16'h1);
         u_acotc_host.wr(ADDR_PATTERN, 8'h00);
         settle(7);
         chk(out_bus, sample_data);
      end
      $display("Pattern tests done");
      close_out();
   end
endmodule
